// >>> design/dual_serial_config.sv
// Operation
// - Seven or eight data bits per channel: with seven, the eighth bit of each character is ignored.
// - With parity on, parity is added on transmit and checked on receive.
// - Odd or even parity is chosen per channel.
// - Stop length per channel, one stop bit by default.
// - Rate chosen from fourteen fixed rates, 50 to 230400 bps.
// - 230400 bps is allowed on the first channel only.
// - The second channel alone runs at most 115200 bps.
// - Independent operation: each channel works alone.
// - Linked operation: each received character is resent on the other channel.
// - Sum check option applies under controller access or bidirectional protocol.
// - Online change off: writes while running are refused with a negative answer.
// - Modification permission gates setting changes and flash writes after start.
// - Out-of-range settings fall back to their defaults.
// - Without settings, channels start in engineering_tool_link_mode.
// - engineering_tool_link_mode takes the rate chosen by the tool.
// - Station number for multidrop addressing ranges 0 to 31.
`timescale 1ns/10ps
`include "dual_serial_defines.svh"
module dual_serial_config (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [1:0] i_rxd,
	output logic [1:0] o_txd,
	input wire logic [7:0] i_tool_rate,
	input wire logic i_cpu_running,
	input wire logic [1:0] i_write_req,
	output logic [1:0] o_write_grant,
	output logic [1:0] o_write_nak,
	output logic [1:0] o_sum_check_en,
	output logic [1:0] o_flash_write_ok,
	output logic [4:0] o_station
);
	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Range check of a written setting
	function automatic dual_serial_pkg::chan_cfg_s sanitize(input logic [31:0] w,
		input logic second);
		dual_serial_pkg::chan_cfg_s c;
		logic [3:0] r;
		logic [2:0] p;
		c = '0;
		r = w[`F_RATE_LO+:4];
		p = w[`F_PROTO_LO+:3];
		c.data8 = w[`F_DATA8];
		c.par_en = w[`F_PAR_EN];
		c.par_odd = w[`F_PAR_ODD];
		c.stop2 = w[`F_STOP2];
		c.sum_en = w[`F_SUM];
		c.online_en = w[`F_ONLINE];
		c.modify_en = w[`F_MODIFY];
		if (r <= `RATE_TOP && !(second && r == `RATE_TOP))
			c.rate = r;
		else
			c.rate = `RATE_AUTO;
		if (p < `PROTO_LAST || (p == `PROTO_LAST && !second))
			c.proto = dual_serial_pkg::proto_e'(p);
		else
			c.proto = dual_serial_pkg::PROTO_ENG_LINK;
		return c;
	endfunction : sanitize

	// Clocks per sixteenth of a bit
	function automatic logic [`DIV_W-1:0] rate_div(input logic [3:0] code);
		int bps;
		case (code)
			4'h0: bps = 50;
			4'h1: bps = 300;
			4'h2: bps = 600;
			4'h3: bps = 1200;
			4'h4: bps = 2400;
			4'h5: bps = 4800;
			4'h6: bps = 9600;
			4'h7: bps = 14400;
			4'h8: bps = 19200;
			4'h9: bps = 28800;
			4'ha: bps = 38400;
			4'hb: bps = 57600;
			4'hc: bps = 115200;
			4'hd: bps = 230400;
			default: bps = 9600;
		endcase
		return `DIV_W'(`CLK_HZ / (`OVERSAMPLE * bps));
	endfunction : rate_div

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	dual_serial_pkg::chan_cfg_s cfg [2];
	logic linked;
	logic started;
	logic [4:0] station;
	logic [1:0] perr;
	logic [1:0] rx_full;
	logic [7:0] rx_data [2];
	logic [31:0] next_rdata;

	wire [1:0] rx_valid;
	dual_serial_pkg::rx_char_s rx_char [2];
	wire [1:0] tx_ready;
	wire [1:0] tx_valid;
	wire [7:0] tx_data [2];
	wire [3:0] eff_rate [2];

	wire wr_cfg1 = i_wr && i_addr == `ADDR_CFG_FIRST;
	wire wr_cfg2 = i_wr && i_addr == `ADDR_CFG_SECOND;
	wire wr_ctrl = i_wr && i_addr == `ADDR_CTRL;
	wire wr_stat = i_wr && i_addr == `ADDR_STAT;
	wire wr_tx1 = i_wr && i_addr == `ADDR_TX_FIRST;
	wire wr_tx2 = i_wr && i_addr == `ADDR_TX_SECOND;
	wire rd_rx1 = i_rd && i_addr == `ADDR_RX_FIRST;
	wire rd_rx2 = i_rd && i_addr == `ADDR_RX_SECOND;
	wire cfg1_open = !started || cfg[0].modify_en;
	wire cfg2_open = !started || cfg[1].modify_en;
	wire ctrl_open = !started || (cfg[0].modify_en && cfg[1].modify_en);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cfg[0] <= sanitize(`CFG_RESET, 1'b0);
			cfg[1] <= sanitize(`CFG_RESET, 1'b1);
			linked <= 1'b0;
			station <= 5'h00;
			started <= 1'b0;
		end else begin
			if (wr_cfg1 && cfg1_open)
				cfg[0] <= sanitize(i_wdata, 1'b0);
			if (wr_cfg2 && cfg2_open)
				cfg[1] <= sanitize(i_wdata, 1'b1);
			if (wr_ctrl && ctrl_open) begin
				linked <= i_wdata[`F_LINKED];
				station <= i_wdata[`F_STATION_LO+:5];
			end
			if (wr_ctrl && i_wdata[`F_START])
				started <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Channels

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			logic [`DIV_W-1:0] cnt;
			logic tick;
			wire [3:0] tool = i_tool_rate[4*ch+:4];
			wire use_tool = cfg[ch].proto == dual_serial_pkg::PROTO_ENG_LINK ||
				cfg[ch].rate == `RATE_AUTO;
			wire tool_ok = tool <= `RATE_TOP && !(ch == 1 && tool == `RATE_TOP);
			assign eff_rate[ch] = !use_tool ? cfg[ch].rate :
				(tool_ok ? tool : `RATE_TOOL_DFLT);
			wire [`DIV_W-1:0] div = rate_div(eff_rate[ch]);

			always_ff @(posedge i_clk) begin
				if (i_sys_rst || tick)
					cnt <= '0;
				else
					cnt <= cnt + `DIV_W'(1);
			end
			always_ff @(posedge i_clk) begin
				if (i_sys_rst)
					tick <= 1'b0;
				else
					tick <= (cnt >= div - `DIV_W'(2)) && !tick;
			end

			serial_tx u_tx (
				.i_clk(i_clk),
				.i_sys_rst(i_sys_rst),
				.i_tick(tick),
				.i_cfg(cfg[ch]),
				.i_valid(tx_valid[ch]),
				.i_data(tx_data[ch]),
				.o_ready(tx_ready[ch]),
				.o_txd(o_txd[ch])
			);

			serial_rx u_rx (
				.i_clk(i_clk),
				.i_sys_rst(i_sys_rst),
				.i_tick(tick),
				.i_cfg(cfg[ch]),
				.i_rxd(i_rxd[ch]),
				.o_valid(rx_valid[ch]),
				.o_char(rx_char[ch])
			);

			assign tx_valid[ch] = linked ? rx_valid[1-ch] :
				(ch == 0 ? wr_tx1 : wr_tx2);
			assign tx_data[ch] = linked ? rx_char[1-ch].data : i_wdata[7:0];

			assign o_sum_check_en[ch] = cfg[ch].sum_en &&
				(cfg[ch].proto == dual_serial_pkg::PROTO_CTRL_ACCESS ||
				cfg[ch].proto == dual_serial_pkg::PROTO_BIDIR);
			assign o_write_grant[ch] = i_write_req[ch] && (cfg[ch].online_en || !i_cpu_running);
			assign o_write_nak[ch] = i_write_req[ch] && !cfg[ch].online_en && i_cpu_running;
			assign o_flash_write_ok[ch] = !started || cfg[ch].modify_en;

			wire rd_rx = ch == 0 ? rd_rx1 : rd_rx2;
			wire perr_clr = wr_stat && i_wdata[ch];
			always_ff @(posedge i_clk) begin
				if (i_sys_rst) begin
					perr[ch] <= 1'b0;
					rx_full[ch] <= 1'b0;
					rx_data[ch] <= 8'h00;
				end else begin
					if (rx_valid[ch] && rx_char[ch].perr)
						perr[ch] <= 1'b1;
					else if (perr_clr)
						perr[ch] <= 1'b0;
					if (rx_valid[ch] && !linked) begin
						rx_full[ch] <= 1'b1;
						rx_data[ch] <= rx_char[ch].data;
					end else if (rd_rx)
						rx_full[ch] <= 1'b0;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Read port

	wire [31:0] cfg_word [2];
	generate
		for (ch = 0; ch < 2; ch++) begin : g_word
			assign cfg_word[ch] = {17'h0, cfg[ch].proto, cfg[ch].rate, 1'b0,
				cfg[ch].modify_en, cfg[ch].online_en, cfg[ch].sum_en, cfg[ch].stop2,
				cfg[ch].par_odd, cfg[ch].par_en, cfg[ch].data8};
		end
	endgenerate

	wire [31:0] ctrl_word = {19'h0, station, 6'h0, started, linked};
	wire [31:0] stat_word = {16'h0, eff_rate[1], eff_rate[0], 1'b0, started,
		~tx_ready, rx_full, perr};

	always_comb begin
		case (i_addr)
			`ADDR_CFG_FIRST: next_rdata = cfg_word[0];
			`ADDR_CFG_SECOND: next_rdata = cfg_word[1];
			`ADDR_CTRL: next_rdata = ctrl_word;
			`ADDR_STAT: next_rdata = stat_word;
			`ADDR_RX_FIRST: next_rdata = {23'h0, rx_full[0], rx_data[0]};
			`ADDR_RX_SECOND: next_rdata = {23'h0, rx_full[1], rx_data[1]};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_rdata <= 32'h0000_0000;
		else
			o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
	end

	assign o_station = station;
endmodule : dual_serial_config

// >>> design/dual_serial_defines.svh
`ifndef DUAL_SERIAL_DEFINES_SVH
`define DUAL_SERIAL_DEFINES_SVH
// Register offsets
`define ADDR_CFG_FIRST 8'h00
`define ADDR_CFG_SECOND 8'h04
`define ADDR_CTRL 8'h08
`define ADDR_STAT 8'h0c
`define ADDR_TX_FIRST 8'h10
`define ADDR_TX_SECOND 8'h14
`define ADDR_RX_FIRST 8'h18
`define ADDR_RX_SECOND 8'h1c
// Channel configuration fields
`define F_DATA8 0
`define F_PAR_EN 1
`define F_PAR_ODD 2
`define F_STOP2 3
`define F_SUM 4
`define F_ONLINE 5
`define F_MODIFY 6
`define F_RATE_LO 8
`define F_PROTO_LO 12
// Control fields
`define F_LINKED 0
`define F_START 1
`define F_STATION_LO 8
// Reset values: 7 data bits, no parity, odd, 1 stop, auto rate, tool link
`define CFG_RESET 32'h0000_0f04
`define CTRL_RESET 32'h0000_0000
// Rate and protocol codes
`define RATE_AUTO 4'hf
`define RATE_TOP 4'hd
`define RATE_TOOL_DFLT 4'h6
`define PROTO_LAST 3'h4
// Timing
`define CLK_HZ 40000000
`define OVERSAMPLE 16
`define DIV_W 16
`endif

// >>> design/dual_serial_pkg.sv
package dual_serial_pkg;
	typedef enum logic [2:0] {
		PROTO_ENG_LINK,
		PROTO_CTRL_ACCESS,
		PROTO_NONPROC,
		PROTO_BIDIR,
		PROTO_LINKED_SET
	} proto_e;

	typedef struct packed {
		proto_e proto;
		logic [3:0] rate;
		logic modify_en;
		logic online_en;
		logic sum_en;
		logic stop2;
		logic par_odd;
		logic par_en;
		logic data8;
	} chan_cfg_s;

	typedef struct packed {
		logic [7:0] data;
		logic perr;
	} rx_char_s;
endpackage : dual_serial_pkg

// >>> design/serial_rx.sv
`timescale 1ns/10ps
module serial_rx (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input dual_serial_pkg::chan_cfg_s i_cfg,
	input wire logic i_rxd,
	output logic o_valid,
	output dual_serial_pkg::rx_char_s o_char
);
	typedef enum logic [2:0] {IDLE, START, DATA, PARITY, STOP} rx_state_e;
	rx_state_e state;
	logic [3:0] sub;
	logic [2:0] bitn;
	logic [7:0] shreg;
	logic par;

	wire sample = i_tick && (sub == 4'hf);
	wire [2:0] last_bit = i_cfg.data8 ? 3'h7 : 3'h6;
	wire [7:0] got = i_cfg.data8 ? shreg : {1'b0, shreg[7:1]};
	wire perr = i_cfg.par_en && (((^got) ^ par) != i_cfg.par_odd);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= IDLE;
			sub <= 4'h0;
			bitn <= 3'h0;
			shreg <= 8'h00;
			par <= 1'b0;
			o_valid <= 1'b0;
			o_char <= '0;
		end else begin
			o_valid <= 1'b0;
			if (i_tick)
				sub <= sub + 4'h1;
			case (state)
				IDLE: if (i_tick && !i_rxd) begin
					sub <= 4'h1;
					state <= START;
				end
				START: if (i_tick && sub == 4'h7) begin
					sub <= 4'h0;
					bitn <= 3'h0;
					state <= i_rxd ? IDLE : DATA;
				end
				DATA: if (sample) begin
					shreg <= {i_rxd, shreg[7:1]};
					bitn <= bitn + 3'h1;
					if (bitn == last_bit)
						state <= i_cfg.par_en ? PARITY : STOP;
				end
				PARITY: if (sample) begin
					par <= i_rxd;
					state <= STOP;
				end
				STOP: if (sample) begin
					o_valid <= 1'b1;
					o_char <= '{data: got, perr: perr};
					state <= IDLE;
				end
				default: state <= IDLE;
			endcase
		end
	end
endmodule : serial_rx

// >>> design/serial_tx.sv
`timescale 1ns/10ps
module serial_tx (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input dual_serial_pkg::chan_cfg_s i_cfg,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	output logic o_ready,
	output logic o_txd
);
	typedef enum logic [2:0] {IDLE, START, DATA, PARITY, STOP} tx_state_e;
	tx_state_e state;
	logic [3:0] sub;
	logic [2:0] bitn;
	logic [7:0] shreg;
	logic par;
	logic stopn;

	wire bit_end = i_tick && (sub == 4'hf);
	wire [2:0] last_bit = i_cfg.data8 ? 3'h7 : 3'h6;
	wire [7:0] masked = i_cfg.data8 ? i_data : {1'b0, i_data[6:0]};
	assign o_ready = (state == IDLE);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= IDLE;
			sub <= 4'h0;
			bitn <= 3'h0;
			shreg <= 8'h00;
			par <= 1'b0;
			stopn <= 1'b0;
			o_txd <= 1'b1;
		end else begin
			if (i_tick)
				sub <= sub + 4'h1;
			case (state)
				IDLE: begin
					o_txd <= 1'b1;
					if (i_valid) begin
						shreg <= masked;
						par <= (^masked) ^ i_cfg.par_odd;
						sub <= 4'h0;
						o_txd <= 1'b0;
						state <= START;
					end
				end
				START: if (bit_end) begin
					bitn <= 3'h0;
					o_txd <= shreg[0];
					state <= DATA;
				end
				DATA: if (bit_end) begin
					shreg <= {1'b0, shreg[7:1]};
					bitn <= bitn + 3'h1;
					if (bitn == last_bit) begin
						stopn <= 1'b0;
						o_txd <= i_cfg.par_en ? par : 1'b1;
						state <= i_cfg.par_en ? PARITY : STOP;
					end else
						o_txd <= shreg[1];
				end
				PARITY: if (bit_end) begin
					o_txd <= 1'b1;
					state <= STOP;
				end
				STOP: if (bit_end) begin
					stopn <= 1'b1;
					if (stopn || !i_cfg.stop2)
						state <= IDLE;
				end
				default: state <= IDLE;
			endcase
		end
	end
endmodule : serial_tx

// >>> tb/dual_serial_config_assertions.sv
`timescale 1ns/10ps
module dual_serial_config_assertions (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] i_rxd,
	input wire logic [1:0] o_txd,
	input wire logic [7:0] i_tool_rate,
	input wire logic i_cpu_running,
	input wire logic [1:0] i_write_req,
	input wire logic [1:0] o_write_grant,
	input wire logic [1:0] o_write_nak,
	input wire logic [1:0] o_sum_check_en,
	input wire logic [1:0] o_flash_write_ok,
	input wire logic [4:0] o_station
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////
	AST_NAK_GRANT: assert property ((o_write_nak & o_write_grant) == 2'h0)
		else $error("nak and grant together");
	AST_ANSWERED: assert property ((o_write_nak | o_write_grant) == i_write_req)
		else $error("write request not answered");
	AST_IDLE_GRANT: assert property (!i_cpu_running |-> o_write_grant == i_write_req)
		else $error("write refused while stopped");
	AST_RST_STATE: assert property ($past(i_sys_rst) |->
		o_txd == 2'h3 && o_station == 5'h0 && o_flash_write_ok == 2'h3)
		else $error("wrong state after reset");
	AST_START_FIRST: assert property ($fell(o_txd[0]) |-> !o_txd[0] [*8])
		else $error("start bit too short on first channel");
	AST_START_SECOND: assert property ($fell(o_txd[1]) |-> ##1 !o_txd[1] [*7])
		else $error("start bit too short on second channel");
	AST_STATION: assert property (!$past(i_wr) |-> $stable(o_station))
		else $error("station moved without a write");
	AST_SUM_HOLD: assert property (!$past(i_wr) |->
		$stable(o_sum_check_en) && $stable(o_flash_write_ok))
		else $error("option output moved without a write");
endmodule : dual_serial_config_assertions

// >>> tb/dual_serial_config_tb_top.sv
`timescale 1ns/10ps
module dual_serial_config_tb_top;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	localparam logic [31:0] CA = 32'h2c5e;
	localparam logic [31:0] CB = 32'h1c73;
	logic i_clk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic [7:0] i_addr = 8'h0;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'h0;
	logic i_rd = 1'h0;
	logic [31:0] o_rdata;
	wire [1:0] i_rxd;
	logic [1:0] o_txd, o_write_grant, o_write_nak, o_sum_check_en, o_flash_write_ok;
	logic [7:0] i_tool_rate = 8'h6c;
	logic i_cpu_running = 1'h0;
	logic [1:0] i_write_req = 2'h0;
	logic [4:0] o_station;
	logic [7:0] d;
	int st;
	int n_fail = 0;
	int checks = 0;
	logic [7:0] ta [4] = '{8'h04, 8'h00, 8'h04, 8'h00};
	logic [31:0] tw [4] = '{32'h1d73, 32'h7e04, 32'h4c04, 32'h2d5e};
	logic [31:0] te [4] = '{32'h1f73, 32'h0f04, 32'h0c04, 32'h2d5e};
	always #12.5 i_clk = ~i_clk;
	dual_serial_config dut (.*);
	serial_line_model m0 (.i_clk(i_clk), .i_line(o_txd[0]), .o_line(i_rxd[0]));
	serial_line_model m1 (.i_clk(i_clk), .i_line(o_txd[1]), .o_line(i_rxd[1]));
	////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	task automatic cmp(input string s, input logic [31:0] e, v);
		checks++;
		if (v !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", s, e, v);
		end
	endtask : cmp
	task automatic frame(input int s);
		if (s == 2) begin
			n_fail++;
			print_verdict();
		end else cmp("frame", 32'h0, 32'(s));
	endtask : frame
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'h1;
		@(posedge i_clk);
		i_wr <= 1'h0;
		@(posedge i_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input string s);
		i_addr <= a;
		i_rd <= 1'h1;
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1;
		cmp(s, e, o_rdata & m);
		@(posedge i_clk);
	endtask : rd
	////////////////////////////////////////
	initial begin
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'h0;
		@(posedge i_clk);
		rd(8'h00, 32'h0f04, ALL, "cfg first");
		rd(8'h04, 32'h0f04, ALL, "cfg second");
		rd(8'h0c, 32'h6c00, ALL, "status");
		i_tool_rate <= 8'he6;
		rd(8'h0c, 32'h6600, 32'hff00, "tool rate");
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			wr(ta[i], tw[i]);
			rd(ta[i], te[i], ALL, "sanitized");
		end
		for (int r = 0; r < 14; r++) begin
			wr(8'h00, 32'h2000 | (32'(r) << 8));
			rd(8'h0c, 32'(r) << 8, 32'h0f00, "rate");
		end
		$display("test settings done");
		wr(8'h00, CA);
		wr(8'h04, CA);
		wr(8'h08, 32'h1);
		fork
			m0.send(8'h35, 7, 1'h1, 1'h1, 1'h1, 1'h0);
			m1.recv(7, 1'h1, 1'h1, 1'h1, d, st);
		join
		frame(st);
		cmp("linked data", 32'h35, {24'h0, d});
		wr(8'h08, 32'h0);
		$display("test linked done");
		wr(8'h04, CB);
		rd(8'h04, CB, ALL, "second cfg");
		fork
			wr(8'h10, 32'hb5);
			m0.recv(7, 1'h1, 1'h1, 1'h1, d, st);
		join
		frame(st);
		cmp("tx data", 32'h35, {24'h0, d});
		m1.send(8'ha6, 8, 1'h1, 1'h0, 1'h0, 1'h0);
		rd(8'h1c, 32'h1a6, 32'h1ff, "rx second");
		rd(8'h18, 32'h0, 32'h100, "rx first");
		rd(8'h0c, 32'h0, 32'h3, "no perr");
		m1.send(8'h5a, 8, 1'h1, 1'h0, 1'h0, 1'h1);
		rd(8'h0c, 32'h2, 32'h3, "perr set");
		wr(8'h0c, 32'h2);
		rd(8'h0c, 32'h0, 32'h3, "perr clear");
		$display("test serial done");
		i_cpu_running <= 1'h1;
		i_write_req <= 2'h3;
		@(posedge i_clk);
		cmp("grant nak", 32'h9, {28'h0, o_write_grant, o_write_nak});
		i_cpu_running <= 1'h0;
		@(posedge i_clk);
		cmp("grant nak", 32'hc, {28'h0, o_write_grant, o_write_nak});
		i_write_req <= 2'h0;
		cmp("sum", 32'h2, {30'h0, o_sum_check_en});
		wr(8'h00, 32'h3c5f);
		cmp("sum", 32'h3, {30'h0, o_sum_check_en});
		$display("test options done");
		wr(8'h00, 32'h3c1f);
		wr(8'h08, 32'h1f02);
		cmp("station", 32'h1f, {27'h0, o_station});
		cmp("flash", 32'h2, {30'h0, o_flash_write_ok});
		wr(8'h00, 32'h3c5f);
		rd(8'h00, 32'h3c1f, ALL, "locked cfg");
		wr(8'h08, 32'h0501);
		rd(8'h08, 32'h1f00, 32'h1f01, "locked ctrl");
		$display("test start done");
		print_verdict();
	end
endmodule : dual_serial_config_tb_top

bind dual_serial_config dual_serial_config_assertions chk (.*);

// >>> tb/serial_line_model.sv
`timescale 1ns/10ps
module serial_line_model #(parameter int BIT = 336) (
	input wire logic i_clk,
	input wire logic i_line,
	output logic o_line
);
	initial o_line = 1'h1;
	////////////////////////////////////////
	task automatic hold(input int n);
		repeat (n * BIT) @(posedge i_clk);
	endtask : hold
	task automatic send(input logic [7:0] d, input int n, input logic pe, od, s2, bad);
		o_line <= 1'h0;
		hold(1);
		for (int i = 0; i < n; i++) begin
			o_line <= d[i];
			hold(1);
		end
		if (pe) begin
			o_line <= ^d ^ od ^ bad;
			hold(1);
		end
		o_line <= 1'h1;
		hold(s2 ? 2 : 1);
	endtask : send
	task automatic recv(input int n, input logic pe, od, s2, output logic [7:0] d,
		output int st);
		int k;
		d = 8'h0;
		st = 0;
		k = 0;
		while (i_line && k < 40000) begin
			@(posedge i_clk);
			k++;
		end
		if (k == 40000) begin
			st = 2;
		end else begin
			repeat (BIT / 2) @(posedge i_clk);
			for (int i = 0; i < n; i++) begin
				hold(1);
				d[i] = i_line;
			end
			if (pe) begin
				hold(1);
				if (i_line !== (^d ^ od)) st = 1;
			end
			for (int i = 0; i < (s2 ? 2 : 1); i++) begin
				hold(1);
				if (i_line !== 1'h1) st = 1;
			end
		end
	endtask : recv
endmodule : serial_line_model
